// file: tb/bbs_power_stage.sv
`timescale 1ns/10ps
// inductor current comparators seen from the switch states
module bbs_power_stage (
  input wire logic i_clk,
  input wire logic i_buck_low_switch,
  input wire logic i_boost_low_switch,
  input wire logic [7:0] i_dly,
  output logic o_valley_hit,
  output logic o_peak_hit
);
  logic [7:0] vcnt_r;
  logic [7:0] pcnt_r;
  // current falls while buck low side conducts
  always_ff @(posedge i_clk) begin
    if (!i_buck_low_switch) vcnt_r <= 8'h00;
    else if (vcnt_r != 8'hff) vcnt_r <= vcnt_r + 8'h01;
  end
  // current rises while boost low side conducts
  always_ff @(posedge i_clk) begin
    if (!i_boost_low_switch) pcnt_r <= 8'h00;
    else if (pcnt_r != 8'hff) pcnt_r <= pcnt_r + 8'h01;
  end
  assign o_valley_hit = i_buck_low_switch && (vcnt_r >= i_dly);
  assign o_peak_hit = i_boost_low_switch && (pcnt_r >= i_dly);
endmodule

// file: tb/tb_bbs_seq.sv
`timescale 1ns/10ps
module tb_bbs_seq;
  import bbs_pkg::*;
  logic I_CLK = 1'b0;
  logic I_RST_B = 1'b0;
  logic I_CYCLE_CLK = 1'b0;
  logic I_VIN_OV = 1'b0;
  logic I_VIN_UV_INT = 1'b0;
  logic I_ENABLE_UNDERVOLTAGE_INPUT = 1'b1;
  logic [BBS_VW-1:0] I_VIN = 12'h3e8;
  logic [BBS_VW-1:0] I_VBUS = 12'h1f4;
  logic [7:0] dly = 8'h0f;
  logic bh, bl, oh, ol, rb, run, vhit, phit;
  logic [1:0] reg_o;
  logic [4:0] gv;
  logic [4:0] g [0:59];
  int nbl, nol;
  int n_mismatch = 0;
  int checks_done = 0;

  assign gv = {bh, bl, oh, ol, rb};

  bbs_seq i_bbs_seq (
    .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_CYCLE_CLK(I_CYCLE_CLK),
    .VALLEY_CURRENT_LIMIT_HIT(vhit), .I_PEAK_HIT(phit), .I_VIN_OV(I_VIN_OV),
    .I_VIN_UV_INT(I_VIN_UV_INT),
    .I_ENABLE_UNDERVOLTAGE_INPUT(I_ENABLE_UNDERVOLTAGE_INPUT),
    .I_VIN(I_VIN), .I_VBUS(I_VBUS), .O_BUCK_HIGH_SWITCH(bh),
    .O_BUCK_LOW_SWITCH(bl), .O_BOOST_HIGH_SWITCH(oh), .O_BOOST_LOW_SWITCH(ol),
    .O_REVERSE_BLOCK_SWITCH(rb), .O_RUNNING(run), .O_REGION(reg_o)
  );

  bbs_power_stage i_bbs_power_stage (
    .i_clk(I_CLK), .i_buck_low_switch(bl), .i_boost_low_switch(ol),
    .i_dly(dly), .o_valley_hit(vhit), .o_peak_hit(phit)
  );

  initial begin
    forever #10 I_CLK = ~I_CLK;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge I_CLK);
    #1;
  endtask

  // one switching period of 60 clocks; optional input change mid-cycle
  task automatic run_cycle(input logic [11:0] mvbus, input logic [1:0] flt);
    logic [4:0] p;
    p = gv;
    nbl = 0;
    nol = 0;
    for (int i = 0; i < 60; i++) begin
      I_CYCLE_CLK = (i < 10);
      if (i == 30) begin
        I_VBUS = mvbus;
        I_VIN_OV = (flt == 2'h1);
        I_VIN_UV_INT = (flt == 2'h2);
        I_ENABLE_UNDERVOLTAGE_INPUT = (flt != 2'h3);
      end
      tick();
      g[i] = gv;
      nbl += int'(gv[3]);
      nol += int'(gv[1]);
      check({gv[4] & gv[3], gv[2] & gv[1]}, 32'h0);
      check({p[3] & gv[4], p[4] & gv[3], p[1] & gv[2], p[2] & gv[1]}, 32'h0);
      p = gv;
    end
  endtask

  task automatic phases(input logic [4:0] e1, input logic [4:0] e2);
    check(g[10], e1);
    check(g[55], e2);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 10; i++) begin
      tick();
      check({gv, run}, 32'h0);
    end
    I_RST_B = 1'b1;
    for (int i = 0; i < 5; i++) tick();
  endtask

  task automatic t_buck();
    I_VIN = 12'h3e8;
    I_VBUS = 12'h1f4;
    run_cycle(12'h1f4, 2'h0);
    run_cycle(12'h2bc, 2'h0);
    phases(5'h0d, 5'h15);
    check(run, 32'h1);
    check(reg_o, 32'(BBS_REG_BUCK));
  endtask

  task automatic t_boost();
    I_VIN = 12'h1f4;
    run_cycle(12'h2bc, 2'h0);
    phases(5'h13, 5'h15);
    check(reg_o, 32'(BBS_REG_BOOST));
    dly = 8'h23;
    run_cycle(12'h2bc, 2'h0);
    check(g[30], 5'h13);
    check(g[55], 5'h15);
    dly = 8'h0f;
  endtask

  task automatic t_buck_tr();
    I_VIN = 12'h3e8;
    I_VBUS = 12'h384;
    run_cycle(12'h384, 2'h0);
    phases(5'h0d, 5'h15);
    check(reg_o, 32'(BBS_REG_BUCK_TR));
    run_cycle(12'h384, 2'h0);
    phases(5'h13, 5'h15);
    check(nol, BBS_TON_CYC);
    run_cycle(12'h384, 2'h0);
    phases(5'h0d, 5'h15);
  endtask

  task automatic t_boost_tr();
    I_VBUS = 12'h44c;
    run_cycle(12'h44c, 2'h0);
    phases(5'h13, 5'h15);
    check(reg_o, 32'(BBS_REG_BOOST_TR));
    run_cycle(12'h44c, 2'h0);
    phases(5'h0d, 5'h15);
    check(nbl, BBS_TOFF_CYC);
    run_cycle(12'h44c, 2'h0);
    phases(5'h13, 5'h15);
  endtask

  task automatic t_fault(input logic [1:0] flt);
    I_VIN = 12'h3e8;
    I_VBUS = 12'h1f4;
    run_cycle(12'h1f4, flt);
    check(g[45], 32'h0);
    check(run, 32'h0);
    I_VIN_OV = 1'b0;
    I_VIN_UV_INT = 1'b0;
    I_ENABLE_UNDERVOLTAGE_INPUT = 1'b1;
    run_cycle(12'h1f4, 2'h0);
    run_cycle(12'h1f4, 2'h0);
    check(run, 32'h1);
    check(g[55], 5'h15);
  endtask

  task automatic results();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    results();
  end

  initial begin
    t_reset();
    t_buck();
    t_boost();
    t_buck_tr();
    t_boost_tr();
    for (int f = 1; f < 4; f++) t_fault(2'(f));
    results();
  end
endmodule

// file: verilog/bbs_deadtime.sv
`timescale 1ns/10ps
module bbs_deadtime
  import bbs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  bbs_gate_if.dst cmd,
  output logic [4:0] o_gate
);
  // o_gate: {reverse_block, boost_low, boost_high, buck_low, buck_high}
  logic [BBS_TW-1:0] cnt_a_r;
  logic [BBS_TW-1:0] cnt_b_r;
  logic [1:0] pa_r;
  logic [1:0] pb_r;

  // drive a pair; both off while the dead counter runs
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pa_r <= 2'h0;
      cnt_a_r <= '0;
    end else if ({cmd.buck_low_switch, cmd.buck_high_switch} != pa_r) begin
      if (pa_r != 2'h0 && cnt_a_r == '0) begin
        pa_r <= 2'h0;
        cnt_a_r <= BBS_DEAD_CNT;
      end else if (cnt_a_r > 8'h01) begin
        cnt_a_r <= cnt_a_r - 8'h01;
      end else begin
        pa_r <= {cmd.buck_low_switch, cmd.buck_high_switch};
        cnt_a_r <= '0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pb_r <= 2'h0;
      cnt_b_r <= '0;
    end else if ({cmd.boost_low_switch, cmd.boost_high_switch} != pb_r) begin
      if (pb_r != 2'h0 && cnt_b_r == '0) begin
        pb_r <= 2'h0;
        cnt_b_r <= BBS_DEAD_CNT;
      end else if (cnt_b_r > 8'h01) begin
        cnt_b_r <= cnt_b_r - 8'h01;
      end else begin
        pb_r <= {cmd.boost_low_switch, cmd.boost_high_switch};
        cnt_b_r <= '0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_gate <= BBS_SW_OFF;
    end else begin
      o_gate <= {cmd.reverse_block_switch, pb_r, pa_r};
    end
  end

  property p_no_shoot;
    @(posedge i_clk) disable iff (!i_rst_b)
      !(o_gate[0] && o_gate[1]) && !(o_gate[2] && o_gate[3]);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("pair shoot-through");
endmodule

// file: verilog/bbs_gate_if.sv
`timescale 1ns/10ps
// commanded switch states passed to the dead-time stage
interface bbs_gate_if;
  logic buck_high_switch;
  logic buck_low_switch;
  logic boost_high_switch;
  logic boost_low_switch;
  logic reverse_block_switch;
  modport src (output buck_high_switch, buck_low_switch, boost_high_switch,
    boost_low_switch, reverse_block_switch);
  modport dst (input buck_high_switch, buck_low_switch, boost_high_switch,
    boost_low_switch, reverse_block_switch);
endinterface

// file: verilog/bbs_pkg.sv
package bbs_pkg;
  // operating region chosen from the input and bus voltage codes
  typedef enum logic [1:0] {
    BBS_REG_BUCK,
    BBS_REG_BUCK_TR,
    BBS_REG_BOOST_TR,
    BBS_REG_BOOST
  } bbs_region_t;

  // voltage codes are unsigned ADC-style words
  localparam int BBS_VW = 12;
  // ratio k = 1.2 expressed as 6/5
  localparam int BBS_K_NUM = 6;
  localparam int BBS_K_DEN = 5;

  localparam int BBS_CLK_MHZ = 50;
  // non-overlap dead time in ns, rounded up to cycles
  localparam int BBS_DEAD_NS = 40;
  localparam int BBS_DEAD_CYC = (BBS_DEAD_NS * BBS_CLK_MHZ + 999) / 1000;
  // fixed boost on-time and fixed buck off-time in ns, rounded down
  localparam int BBS_TON_NS = 400;
  localparam int BBS_TON_CYC = (BBS_TON_NS * BBS_CLK_MHZ) / 1000;
  localparam int BBS_TOFF_NS = 400;
  localparam int BBS_TOFF_CYC = (BBS_TOFF_NS * BBS_CLK_MHZ) / 1000;
  localparam int BBS_TW = 8;
  localparam logic [BBS_TW-1:0] BBS_TON_CNT = BBS_TW'(BBS_TON_CYC);
  localparam logic [BBS_TW-1:0] BBS_TOFF_CNT = BBS_TW'(BBS_TOFF_CYC);
  localparam logic [BBS_TW-1:0] BBS_DEAD_CNT = BBS_TW'(BBS_DEAD_CYC);

  localparam logic [4:0] BBS_SW_OFF = 5'h00;
endpackage

// file: verilog/bbs_region_sel.sv
`timescale 1ns/10ps
module bbs_region_sel
  import bbs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [BBS_VW-1:0] i_vin,
  input wire logic [BBS_VW-1:0] i_vbus,
  output bbs_region_t o_region
);
  logic [BBS_VW+3:0] vin_k;
  logic [BBS_VW+3:0] vbus_k;
  logic [BBS_VW+3:0] vin_d;
  logic [BBS_VW+3:0] vbus_d;
  bbs_region_t region_nxt;

  // scale by small integer without losing bits
  function automatic logic [BBS_VW+3:0] bbs_scale(input logic [BBS_VW-1:0] v, input int m);
    bbs_scale = (BBS_VW+4)'(v) * (BBS_VW+4)'(m);
  endfunction

  always_comb begin
    vin_k = bbs_scale(i_vin, BBS_K_NUM);
    vin_d = bbs_scale(i_vin, BBS_K_DEN);
    vbus_k = bbs_scale(i_vbus, BBS_K_NUM);
    vbus_d = bbs_scale(i_vbus, BBS_K_DEN);
    if (vbus_d > vin_k) begin
      region_nxt = BBS_REG_BOOST;
    end else if (i_vbus > i_vin) begin
      region_nxt = BBS_REG_BOOST_TR;
    end else if (vbus_k > vin_d) begin
      region_nxt = BBS_REG_BUCK_TR;
    end else begin
      region_nxt = BBS_REG_BUCK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_region <= BBS_REG_BUCK;
    end else begin
      o_region <= region_nxt;
    end
  end
endmodule

// file: verilog/bbs_seq.sv
`timescale 1ns/10ps
// How it works
// - fixed-frequency current mode, forced continuous conduction
// - drive five switches across both nodes
// - blocking switch stops reverse output conduction
// - buck: boost high and block on
// - buck cycle: low first, swap at valley
// - buck duty set by valley comparator
// - buck transition: buck cycle swaps at valley
// - buck transition boost cycle: fixed on-time
// - buck transition: only buck duty varies
// - boost transition: boost cycle swaps at peak
// - boost transition buck cycle: fixed off-time
// - boost transition: only boost duty varies
// - boost: low on until peak, swap
// - boost duty set by peak comparator
// - stop switching on input overvoltage
// - stop switching on any undervoltage
module bbs_seq
  import bbs_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_CYCLE_CLK,
  input wire logic VALLEY_CURRENT_LIMIT_HIT,
  input wire logic I_PEAK_HIT,
  input wire logic I_VIN_OV,
  input wire logic I_VIN_UV_INT,
  input wire logic I_ENABLE_UNDERVOLTAGE_INPUT,
  input wire logic [BBS_VW-1:0] I_VIN,
  input wire logic [BBS_VW-1:0] I_VBUS,
  output logic O_BUCK_HIGH_SWITCH,
  output logic O_BUCK_LOW_SWITCH,
  output logic O_BOOST_HIGH_SWITCH,
  output logic O_BOOST_LOW_SWITCH,
  output logic O_REVERSE_BLOCK_SWITCH,
  output logic O_RUNNING,
  output logic [1:0] O_REGION
);
  typedef enum logic [1:0] {
    BBS_PH_FIRST,
    BBS_PH_SECOND,
    BBS_PH_STOP
  } bbs_phase_t;

  logic clk_s1_r, clk_s2_r, clk_s3_r;
  logic val_s1_r, val_s2_r;
  logic pk_s1_r, pk_s2_r;
  logic ov_s1_r, ov_s2_r;
  logic uv_s1_r, uv_s2_r;
  logic en_s1_r, en_s2_r;
  logic cycle_start;
  logic fault;
  bbs_region_t region_live;
  bbs_region_t region_r;
  bbs_phase_t phase_r;
  logic alt_r;
  logic [BBS_TW-1:0] tmr_r;
  logic [4:0] cmd_nxt;
  logic [4:0] gate;
  bbs_gate_if gif ();

  // pins cross into I_CLK through two flops
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      {clk_s1_r, clk_s2_r, clk_s3_r} <= 3'h0;
      {val_s1_r, val_s2_r, pk_s1_r, pk_s2_r} <= 4'h0;
      {ov_s1_r, ov_s2_r, uv_s1_r, uv_s2_r} <= 4'hf;
      {en_s1_r, en_s2_r} <= 2'h0;
    end else begin
      clk_s1_r <= I_CYCLE_CLK;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      val_s1_r <= VALLEY_CURRENT_LIMIT_HIT;
      val_s2_r <= val_s1_r;
      pk_s1_r <= I_PEAK_HIT;
      pk_s2_r <= pk_s1_r;
      ov_s1_r <= I_VIN_OV;
      ov_s2_r <= ov_s1_r;
      uv_s1_r <= I_VIN_UV_INT;
      uv_s2_r <= uv_s1_r;
      en_s1_r <= I_ENABLE_UNDERVOLTAGE_INPUT;
      en_s2_r <= en_s1_r;
    end
  end

  assign cycle_start = clk_s2_r && !clk_s3_r;
  // either undervoltage source stops us, so the greater threshold wins
  assign fault = ov_s2_r || uv_s2_r || !en_s2_r;

  bbs_region_sel u_sel (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_vin(I_VIN),
    .i_vbus(I_VBUS),
    .o_region(region_live)
  );

  // region latched per cycle; alt picks buck/boost in transition regions
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      region_r <= BBS_REG_BUCK;
      alt_r <= 1'b0;
    end else if (cycle_start) begin
      region_r <= region_live;
      if (region_live != region_r) begin
        alt_r <= 1'b0;
      end else begin
        alt_r <= !alt_r;
      end
    end
  end

  // phase machine: first interval ends on comparator or timer
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      phase_r <= BBS_PH_STOP;
      tmr_r <= '0;
    end else if (fault) begin
      phase_r <= BBS_PH_STOP;
      tmr_r <= '0;
    end else if (cycle_start) begin
      phase_r <= BBS_PH_FIRST;
      // dead gap before the switch turns on is added so it conducts the full time
      if (region_live == BBS_REG_BUCK_TR && region_live == region_r && !alt_r) begin
        tmr_r <= BBS_TW'(BBS_TON_CYC + BBS_DEAD_CYC);
      end else if (region_live == BBS_REG_BOOST_TR && region_live == region_r && !alt_r) begin
        tmr_r <= BBS_TW'(BBS_TOFF_CYC + BBS_DEAD_CYC);
      end else begin
        tmr_r <= '0;
      end
    end else begin
      case (phase_r)
        BBS_PH_FIRST: begin
          if (tmr_r != '0) begin
            // fixed interval, comparators ignored
            if (tmr_r == 8'h01) begin
              phase_r <= BBS_PH_SECOND;
            end
            tmr_r <= tmr_r - 8'h01;
          end else if ((region_r == BBS_REG_BUCK || region_r == BBS_REG_BUCK_TR) && val_s2_r) begin
            phase_r <= BBS_PH_SECOND;
          end else if ((region_r == BBS_REG_BOOST || region_r == BBS_REG_BOOST_TR) && pk_s2_r) begin
            phase_r <= BBS_PH_SECOND;
          end
        end
        BBS_PH_SECOND: phase_r <= BBS_PH_SECOND;
        BBS_PH_STOP: phase_r <= BBS_PH_STOP;
        default: phase_r <= BBS_PH_STOP;
      endcase
    end
  end

  // commanded switches {m5, boost_lo, boost_hi, buck_lo, buck_hi}
  logic boost_cyc;
  always_comb begin
    boost_cyc = 1'b0;
    cmd_nxt = BBS_SW_OFF;
    case (region_r)
      BBS_REG_BUCK: boost_cyc = 1'b0;
      BBS_REG_BOOST: boost_cyc = 1'b1;
      // second cycle of a pair flips kind; alt toggled at cycle start
      BBS_REG_BUCK_TR: boost_cyc = alt_r;
      BBS_REG_BOOST_TR: boost_cyc = !alt_r;
      default: boost_cyc = 1'b0;
    endcase
    case (phase_r)
      BBS_PH_FIRST: begin
        if (region_r == BBS_REG_BUCK_TR && boost_cyc) begin
          cmd_nxt = 5'h19;
        end else if (region_r == BBS_REG_BOOST_TR && !boost_cyc) begin
          cmd_nxt = 5'h16;
        end else if (boost_cyc) begin
          cmd_nxt = 5'h19;
        end else begin
          cmd_nxt = 5'h16;
        end
      end
      BBS_PH_SECOND: begin
        cmd_nxt = 5'h15;
      end
      BBS_PH_STOP: begin
        // all off, blocking switch off holds the output
        cmd_nxt = BBS_SW_OFF;
      end
      default: cmd_nxt = BBS_SW_OFF;
    endcase
  end

  assign gif.buck_high_switch = cmd_nxt[0];
  assign gif.buck_low_switch = cmd_nxt[1];
  assign gif.boost_high_switch = cmd_nxt[2];
  assign gif.boost_low_switch = cmd_nxt[3];
  assign gif.reverse_block_switch = cmd_nxt[4];

  bbs_deadtime u_dt (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .cmd(gif.dst),
    .o_gate(gate)
  );

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      {O_REVERSE_BLOCK_SWITCH, O_BOOST_LOW_SWITCH, O_BOOST_HIGH_SWITCH} <= 3'h0;
      {O_BUCK_LOW_SWITCH, O_BUCK_HIGH_SWITCH} <= 2'h0;
      O_RUNNING <= 1'b0;
      O_REGION <= 2'h0;
    end else begin
      O_BUCK_HIGH_SWITCH <= gate[0] && !fault;
      O_BUCK_LOW_SWITCH <= gate[1] && !fault;
      O_BOOST_HIGH_SWITCH <= gate[2] && !fault;
      O_BOOST_LOW_SWITCH <= gate[3] && !fault;
      O_REVERSE_BLOCK_SWITCH <= gate[4] && !fault;
      O_RUNNING <= phase_r != BBS_PH_STOP;
      O_REGION <= region_r;
    end
  end

  property p_fault_off;
    @(posedge I_CLK) disable iff (!I_RST_B)
      fault |=> ##1 !O_BUCK_HIGH_SWITCH && !O_BOOST_LOW_SWITCH;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("switching in fault");

  property p_pair_buck;
    @(posedge I_CLK) disable iff (!I_RST_B)
      !(O_BUCK_HIGH_SWITCH && O_BUCK_LOW_SWITCH);
  endproperty
  a_pair_buck: assert property (p_pair_buck) else $error("buck pair overlap");

  property p_pair_boost;
    @(posedge I_CLK) disable iff (!I_RST_B)
      !(O_BOOST_HIGH_SWITCH && O_BOOST_LOW_SWITCH);
  endproperty
  a_pair_boost: assert property (p_pair_boost) else $error("boost pair overlap");

  property p_region_hold;
    @(posedge I_CLK) disable iff (!I_RST_B)
      !cycle_start |=> $stable(region_r);
  endproperty
  a_region_hold: assert property (p_region_hold) else $error("region moved mid-cycle");

  property p_buck_fixed;
    @(posedge I_CLK) disable iff (!I_RST_B)
      (phase_r == BBS_PH_FIRST && region_r == BBS_REG_BUCK) |-> cmd_nxt == 5'h16;
  endproperty
  a_buck_fixed: assert property (p_buck_fixed) else $error("buck first phase wrong");

  property p_boost_second;
    @(posedge I_CLK) disable iff (!I_RST_B)
      (phase_r == BBS_PH_SECOND) |-> cmd_nxt == 5'h15;
  endproperty
  a_boost_second: assert property (p_boost_second) else $error("second phase wrong");

  property p_timer_end;
    @(posedge I_CLK) disable iff (!I_RST_B || fault || cycle_start)
      (phase_r == BBS_PH_FIRST && tmr_r == 8'h01) |=> phase_r == BBS_PH_SECOND;
  endproperty
  a_timer_end: assert property (p_timer_end) else $error("fixed time missed");

  property p_stop_on_fault;
    @(posedge I_CLK) disable iff (!I_RST_B)
      fault |=> phase_r == BBS_PH_STOP;
  endproperty
  a_stop_on_fault: assert property (p_stop_on_fault) else $error("no stop");

  c_buck: cover property (@(posedge I_CLK) region_r == BBS_REG_BUCK && phase_r == BBS_PH_SECOND);
  c_btr: cover property (@(posedge I_CLK) region_r == BBS_REG_BUCK_TR && tmr_r == 8'h01);
  c_bstr: cover property (@(posedge I_CLK) region_r == BBS_REG_BOOST_TR && tmr_r == 8'h01);
  c_fault: cover property (@(posedge I_CLK) fault && O_RUNNING);
endmodule
